// *** hdl/tiu_unit.sv ***
// interrupt aggregation and counter unit
`include "tiu_params.svh"
`default_nettype none
module tiu_unit import tiu_pkg::*; #(
   parameter int FIFO_DEPTH = 512,
   parameter int CW         = 10
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst,
   // register port
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [5:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic [7:0]         reg_rdata,
   // event sources
   input  wire logic          tx_payload_phase,
   input  wire logic          tx_eof_phase,
   input  wire logic          rx_stream_end,
   input  wire logic          command_is_idle,
   input  wire logic [CW-1:0] fifo_count,
   input  wire logic          rx_active,
   input  wire logic [7:0]    error_status,
   input  wire logic          card_presence_sense,
   input  wire logic          card_presence_sense_mode,
   input  wire logic          frame_start_seen,
   input  wire logic [3:0]    counter_stop_evt,
   // low power oscillator pin
   input  wire logic          low_power_osc,
   // outputs
   output logic               irq_pin,
   output logic               standby_req,
   output logic               stay_powered
);
   localparam int NCNT  = 5;
   localparam int SLOWW = $clog2(`TIU_SLOW_DIV);

   logic [7:0]      pin_ctrl;
   logic [7:0]      water_level;
   logic [6:0]      flags_a;
   logic [6:0]      flags_b;
   logic [6:0]      en_a;
   logic [6:0]      en_b;
   logic [7:0]      cnt_ctrl  [NCNT];
   logic [15:0]     cnt_rel   [NCNT];
   logic [15:0]     cnt_val   [NCNT];
   logic [NCNT-1:0] cnt_run;
   logic [NCNT-1:0] cnt_uf;
   logic [NCNT-1:0] cnt_tick;
   logic [NCNT-1:0] cnt_start;
   logic [NCNT-1:0] cnt_halt;
   logic [NCNT-1:0] start_bit;

   // register decode helpers
   function automatic logic [7:0] apply_setclr(input logic [6:0] old, input logic [7:0] w);
      if (w[`TIU_BIT_SETCLR]) begin
         apply_setclr = {1'b0, old | w[6:0]};
      end else begin
         apply_setclr = {1'b0, old & ~w[6:0]};
      end
   endfunction : apply_setclr

   function automatic logic cnt_hit(input logic [5:0] a, input int idx, input logic [2:0] ofs);
      cnt_hit = (a == 6'(int'(`TIU_ADDR_CNT_BASE) + (idx << `TIU_CNT_STRIDE) + int'(ofs)));
   endfunction : cnt_hit

   wire wr_fa = reg_wr && (reg_addr == `TIU_ADDR_FLAGS_A);
   wire wr_fb = reg_wr && (reg_addr == `TIU_ADDR_FLAGS_B);
   wire wr_gc = reg_wr && (reg_addr == `TIU_ADDR_GCTRL);

   // fast tick by phase accumulator, slow tick by 64
   localparam logic [15:0] ACC_STEP = 16'(`TIU_FAST_KHZ);
   localparam logic [15:0] ACC_MOD  = 16'(`TIU_CLK_KHZ);
   logic [15:0]     acc;
   logic            fast_tick;
   logic [SLOWW-1:0] slow_cnt;
   logic            slow_tick;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc       <= 16'h0000;
         fast_tick <= 1'b0;
      end else if (acc + ACC_STEP >= ACC_MOD) begin
         acc       <= acc + ACC_STEP - ACC_MOD;
         fast_tick <= 1'b1;
      end else begin
         acc       <= acc + ACC_STEP;
         fast_tick <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slow_cnt  <= '0;
         slow_tick <= 1'b0;
      end else begin
         slow_tick <= 1'b0;
         if (fast_tick) begin
            slow_cnt <= slow_cnt + 1'b1;
            if (slow_cnt == '1) begin
               slow_tick <= 1'b1;
            end
         end
      end
   end

   // oscillator pin synchronised, rising edge gives wake tick
   logic lpo_s1;
   logic lpo_s2;
   logic lpo_s3;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lpo_s1 <= 1'b0;
         lpo_s2 <= 1'b0;
         lpo_s3 <= 1'b0;
      end else begin
         lpo_s1 <= low_power_osc;
         lpo_s2 <= lpo_s1;
         lpo_s3 <= lpo_s2;
      end
   end

   // counters
   generate
      for (genvar i = 0; i < NCNT; i++) begin : g_cnt
         if (i < 4) begin : g_sel
            always_comb begin
               unique case (tiu_clk_src_t'(cnt_ctrl[i][`TIU_CTRL_CLK_LSB +: 2]))
                  tiu_src_fast:  cnt_tick[i] = fast_tick;
                  tiu_src_slow:  cnt_tick[i] = slow_tick;
                  tiu_src_chain: cnt_tick[i] = cnt_uf[(i + 3) % 4];
                  default:       cnt_tick[i] = 1'b0;
               endcase
            end
            assign cnt_start[i] = (wr_gc && reg_wdata[i] && reg_wdata[i+4]) || start_bit[i];
            assign cnt_halt[i]  = wr_gc && reg_wdata[i] && !reg_wdata[i+4];
         end else begin : g_wake
            assign cnt_tick[i]  = lpo_s2 && !lpo_s3;
            assign cnt_start[i] = start_bit[i];
            assign cnt_halt[i]  = 1'b0;
         end
         tiu_counter u_cnt (
            .clk         (clk),
            .rst         (rst),
            .tick        (cnt_tick[i]),
            .start       (cnt_start[i]),
            .halt        (cnt_halt[i]),
            .stop_evt    ((i < 4) ? (cnt_ctrl[i][`TIU_CTRL_STOPEVT] && counter_stop_evt[i % 4]) : 1'b0),
            .auto_reload (cnt_ctrl[i][`TIU_CTRL_RELOAD]),
            .reload      (cnt_rel[i]),
            .running     (cnt_run[i]),
            .value       (cnt_val[i]),
            .underflow   (cnt_uf[i])
         );

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt_ctrl[i]  <= `TIU_RST_BYTE;
               cnt_rel[i]   <= {`TIU_RST_BYTE, `TIU_RST_BYTE};
               start_bit[i] <= 1'b0;
            end else begin
               start_bit[i] <= 1'b0;
               if (reg_wr && cnt_hit(reg_addr, i, `TIU_OFS_CTRL)) begin
                  cnt_ctrl[i]  <= reg_wdata & ~(8'h01 << `TIU_CTRL_START);
                  start_bit[i] <= reg_wdata[`TIU_CTRL_START];
               end
               if (reg_wr && cnt_hit(reg_addr, i, `TIU_OFS_REL_HI)) begin
                  cnt_rel[i][15:8] <= reg_wdata;
               end
               if (reg_wr && cnt_hit(reg_addr, i, `TIU_OFS_REL_LO)) begin
                  cnt_rel[i][7:0] <= reg_wdata;
               end
            end
         end
      end
   endgenerate

   // fifo warning levels from one setting
   localparam logic [CW-1:0] DEPTH = CW'(FIFO_DEPTH);
   wire fifo_upper_status = fifo_count >= (DEPTH - CW'(water_level));
   wire fifo_lower_status = fifo_count <= CW'(water_level);

   // previous levels for edge events
   logic tx_pay_q;
   logic idle_q;
   logic upper_q;
   logic lower_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_pay_q <= 1'b0;
         idle_q   <= 1'b1;
         upper_q  <= 1'b0;
         lower_q  <= 1'b1;                                   // empty fifo after reset is no fresh warning
      end else begin
         tx_pay_q <= tx_payload_phase;
         idle_q   <= command_is_idle;
         upper_q  <= fifo_upper_status;
         lower_q  <= fifo_lower_status;
      end
   end

   // flag registers, hardware set wins over host clear
   logic [7:0] wr_a_val;
   logic [7:0] wr_b_val;
   logic [6:0] set_a;
   logic [6:0] set_b;
   logic [6:0] next_flags_a;
   logic [6:0] next_flags_b;
   assign wr_a_val = apply_setclr(flags_a, reg_wdata);
   assign wr_b_val = apply_setclr(flags_b, reg_wdata);

   always_comb begin
      set_a[0] = tx_pay_q && tx_eof_phase;
      set_a[1] = rx_stream_end;
      set_a[2] = command_is_idle && !idle_q;
      set_a[3] = fifo_upper_status && !upper_q;
      set_a[4] = fifo_lower_status && !lower_q;
      set_a[5] = rx_active && (|error_status);
      set_a[6] = card_presence_sense_mode && card_presence_sense;
      set_b[4:0] = cnt_uf;
      set_b[5]   = rx_active && frame_start_seen;
      next_flags_a      = (wr_fa ? wr_a_val[6:0] : flags_a) | set_a;
      next_flags_b[5:0] = (wr_fb ? wr_b_val[5:0] : flags_b[5:0]) | set_b[5:0];
      // global looks at new values, so clearing it with its source sticks
      set_b[6]          = (|(next_flags_a & en_a)) || (|(next_flags_b[5:0] & en_b[5:0]));
      next_flags_b[6]   = (wr_fb ? wr_b_val[6] : flags_b[6]) | set_b[6];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_a <= 7'h00;
      end else begin
         flags_a <= next_flags_a;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_b <= 7'h00;
      end else begin
         flags_b <= next_flags_b;
      end
   end

   // enable and configuration registers
   logic [7:0] en_a_new;
   logic [7:0] en_b_new;
   assign en_a_new = apply_setclr(en_a, reg_wdata);
   assign en_b_new = apply_setclr(en_b, reg_wdata);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_a        <= 7'h00;
         en_b        <= 7'h00;
         pin_ctrl    <= `TIU_RST_BYTE;
         water_level <= `TIU_RST_WATER;
      end else if (reg_wr) begin
         if (reg_addr == `TIU_ADDR_EN_A) begin
            en_a <= en_a_new[6:0];
         end
         if (reg_addr == `TIU_ADDR_EN_B) begin
            en_b <= en_b_new[6:0];
         end
         if (reg_addr == `TIU_ADDR_PIN_CTRL) begin
            pin_ctrl <= reg_wdata;
         end
         if (reg_addr == `TIU_ADDR_WATER) begin
            water_level <= reg_wdata;
         end
      end
   end

   // interrupt pin and status
   wire pending = (|(flags_a & en_a)) || (|(flags_b & en_b));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_pin <= 1'b0;
      end else begin
         irq_pin <= pin_ctrl[0] && pending;
      end
   end

   // wake counter standby control
   wire auto_wake = cnt_ctrl[4][`TIU_CTRL_WAKE];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         standby_req  <= 1'b0;
         stay_powered <= 1'b1;
      end else begin
         standby_req  <= auto_wake && cnt_uf[4] && !flags_a[6];
         stay_powered <= !auto_wake;
      end
   end

   // register read
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         `TIU_ADDR_STATUS:   rd_mux = {7'h00, pending};
         `TIU_ADDR_PIN_CTRL: rd_mux = pin_ctrl;
         `TIU_ADDR_WATER:    rd_mux = water_level;
         `TIU_ADDR_FLAGS_A:  rd_mux = {1'b0, flags_a};
         `TIU_ADDR_FLAGS_B:  rd_mux = {1'b0, flags_b};
         `TIU_ADDR_EN_A:     rd_mux = {1'b0, en_a};
         `TIU_ADDR_EN_B:     rd_mux = {1'b0, en_b};
         `TIU_ADDR_GCTRL:    rd_mux = {cnt_run[3:0], 4'h0};
         default: begin
            for (int k = 0; k < NCNT; k++) begin
               if (cnt_hit(reg_addr, k, `TIU_OFS_CTRL)) begin
                  rd_mux = cnt_ctrl[k];
               end
               if (cnt_hit(reg_addr, k, `TIU_OFS_REL_HI)) begin
                  rd_mux = cnt_rel[k][15:8];
               end
               if (cnt_hit(reg_addr, k, `TIU_OFS_REL_LO)) begin
                  rd_mux = cnt_rel[k][7:0];
               end
               if (cnt_hit(reg_addr, k, `TIU_OFS_VAL_HI)) begin
                  rd_mux = cnt_val[k][15:8];
               end
               if (cnt_hit(reg_addr, k, `TIU_OFS_VAL_LO)) begin
                  rd_mux = cnt_val[k][7:0];
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end
   end
endmodule : tiu_unit
`default_nettype wire

// *** hdl/tiu_params.svh ***
// constants of the timer and interrupt unit
`ifndef TIU_PARAMS_SVH
`define TIU_PARAMS_SVH
`define TIU_ADDR_STATUS   6'h00
`define TIU_ADDR_PIN_CTRL 6'h01
`define TIU_ADDR_WATER    6'h02
`define TIU_ADDR_FLAGS_A  6'h06
`define TIU_ADDR_FLAGS_B  6'h07
`define TIU_ADDR_EN_A     6'h08
`define TIU_ADDR_EN_B     6'h09
`define TIU_ADDR_GCTRL    6'h0f
`define TIU_ADDR_CNT_BASE 6'h10
`define TIU_CNT_STRIDE    3
`define TIU_OFS_CTRL      3'h0
`define TIU_OFS_REL_HI    3'h1
`define TIU_OFS_REL_LO    3'h2
`define TIU_OFS_VAL_HI    3'h3
`define TIU_OFS_VAL_LO    3'h4
`define TIU_BIT_SETCLR    7
`define TIU_CTRL_CLK_LSB  0
`define TIU_CTRL_RELOAD   2
`define TIU_CTRL_STOPEVT  3
`define TIU_CTRL_START    4
`define TIU_CTRL_WAKE     5
`define TIU_FLAG_GLOBAL   6
`define TIU_RST_BYTE      8'h00
`define TIU_RST_WATER     8'h08
`define TIU_CLK_KHZ       40000
`define TIU_FAST_KHZ      13560
`define TIU_SLOW_DIV      64
`endif

// *** hdl/tiu_pkg.sv ***
// types of the timer and interrupt unit
`default_nettype none
package tiu_pkg;
   typedef enum logic [1:0] {tiu_src_fast, tiu_src_slow, tiu_src_chain} tiu_clk_src_t;
endpackage : tiu_pkg
`default_nettype wire

// *** hdl/tiu_counter.sv ***
// one sixteen bit down counter with reload
`default_nettype none
module tiu_counter (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // control
   input  wire logic        tick,
   input  wire logic        start,
   input  wire logic        halt,
   input  wire logic        stop_evt,
   input  wire logic        auto_reload,
   input  wire logic [15:0] reload,
   // state
   output logic             running,
   output logic [15:0]      value,
   output logic             underflow
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         running   <= 1'b0;
         value     <= 16'h0000;
         underflow <= 1'b0;
      end else begin
         underflow <= 1'b0;
         if (start) begin
            running <= 1'b1;
            value   <= reload;
         end else if (halt || (running && stop_evt)) begin
            running <= 1'b0;
         end else if (running && tick) begin
            if (value == 16'h0000) begin
               underflow <= 1'b1;
               if (auto_reload) begin
                  value <= reload;
               end else begin
                  running <= 1'b0;
               end
            end else begin
               value <= value - 16'h0001;
            end
         end
      end
   end
endmodule : tiu_counter
`default_nettype wire

// *** sim/tiu_unit_props.sv ***
// port assertions of the timer and interrupt unit
`default_nettype none
module tiu_unit_props (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // register port
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [5:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // outputs
   input wire logic       irq_pin,
   input wire logic       standby_req,
   input wire logic       stay_powered
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence wr_rd(a, d);
      reg_wr && reg_addr == a && reg_wdata == d ##1 reg_rd && reg_addr == a;
   endsequence
   AST_UNMAPPED: assert property (reg_rd && reg_addr == 6'h05 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_BIT7: assert property (reg_rd && reg_addr inside {[6'h06:6'h09]} |=> !reg_rdata[7])
      else $error("bit seven reads one");
   AST_EN_SET: assert property (wr_rd(6'h08, 8'h81) |=> reg_rdata[0])
      else $error("enable not set");
   AST_EN_CLR: assert property (wr_rd(6'h08, 8'h7f) |=> reg_rdata == 8'h00)
      else $error("enables not cleared");
   AST_FLAG_SET: assert property (wr_rd(6'h07, 8'h81) |=> reg_rdata[0])
      else $error("counter flag not set");
   AST_STOP: assert property (wr_rd(6'h0f, 8'h01) |=> !reg_rdata[4])
      else $error("counter still running");
   AST_STATUS: assert property (reg_rd && reg_addr == 6'h00 |=> !irq_pin || reg_rdata[0])
      else $error("pin without status");
   AST_PIN_OFF: assert property (reg_wr && reg_addr == 6'h01 && !reg_wdata[0] |-> ##2 !irq_pin)
      else $error("pin high while disabled");
   AST_WAKE: assert property (reg_wr && reg_addr == 6'h30 |-> ##2 stay_powered == !$past(reg_wdata[5], 2))
      else $error("stay powered wrong");
   AST_STANDBY: assert property (standby_req |-> !stay_powered ##1 !standby_req)
      else $error("standby pulse wrong");
   cover property (standby_req);
   cover property (wr_rd(6'h07, 8'h81));
   cover property ($rose(irq_pin));
endmodule : tiu_unit_props
bind tiu_unit tiu_unit_props u_props (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .irq_pin,
   .standby_req, .stay_powered);
`default_nettype wire

// *** sim/tiu_host_model.sv ***
// host model: register port driver and interrupt edge counter
`default_nettype none
module tiu_host_model (
   // clock
   input wire logic       clk,
   // register port
   output logic           reg_wr,
   output logic           reg_rd,
   output logic [5:0]     reg_addr,
   output logic [7:0]     reg_wdata,
   input wire logic [7:0] reg_rdata,
   // interrupt
   input wire logic       irq_pin,
   output int             irq_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic irq_q = 1'b0;
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   initial irq_count = 0;
   always @(negedge clk) begin
      irq_q <= irq_pin;
      if (irq_pin === 1'b1 && irq_q !== 1'b1) irq_count <= irq_count + 1;
   end
   // optional write, then read back the same place
   task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      if (w) begin
         reg_wr = 1'b1;
         @(negedge clk);
         reg_wr = 1'b0;
      end
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      q = reg_rdata;
   endtask : access
endmodule : tiu_host_model
`default_nettype wire

// *** sim/tiu_unit_tb_top.sv ***
// self-checking bench of the timer and interrupt unit
`default_nettype none
module tiu_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, reg_wr, reg_rd, tx_payload_phase, tx_eof_phase, rx_stream_end, command_is_idle;
   logic        rx_active, card_presence_sense, card_presence_sense_mode, frame_start_seen, low_power_osc, lpo_on;
   logic        irq_pin, standby_req, stay_powered;
   logic [5:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, error_status, q;
   logic [9:0]  fifo_count;
   logic [3:0]  counter_stop_evt;
   int          error_cnt = 0, check_count = 0, standby_cnt = 0, irq_seen;
   // write flag, address, data, expected read back
   logic [22:0] rows [18] = '{{1'b0, 6'h02, 8'h00, 8'h08}, {1'b0, 6'h06, 8'h00, 8'h00}, {1'b0, 6'h07, 8'h00, 8'h00},
      {1'b0, 6'h0f, 8'h00, 8'h00}, {1'b0, 6'h00, 8'h00, 8'h00}, {1'b1, 6'h08, 8'hff, 8'h7f},
      {1'b1, 6'h08, 8'h0f, 8'h70}, {1'b1, 6'h08, 8'h81, 8'h71}, {1'b1, 6'h08, 8'h7f, 8'h00},
      {1'b1, 6'h07, 8'h81, 8'h01}, {1'b1, 6'h07, 8'h01, 8'h00}, {1'b1, 6'h09, 8'h81, 8'h01},
      {1'b1, 6'h05, 8'hff, 8'h00}, {1'b1, 6'h02, 8'h10, 8'h10}, {1'b1, 6'h01, 8'h00, 8'h00},
      {1'b1, 6'h01, 8'h01, 8'h01}, {1'b1, 6'h11, 8'h00, 8'h00}, {1'b1, 6'h12, 8'h05, 8'h05}};
   tiu_unit dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .tx_payload_phase, .tx_eof_phase,
      .rx_stream_end, .command_is_idle, .fifo_count, .rx_active, .error_status, .card_presence_sense, .card_presence_sense_mode,
      .frame_start_seen, .counter_stop_evt, .low_power_osc, .irq_pin, .standby_req, .stay_powered);
   tiu_host_model host (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .irq_pin, .irq_count(irq_seen));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      low_power_osc = 1'b0;
      forever #200 low_power_osc = lpo_on & ~low_power_osc;
   end
   always @(negedge clk)
      if (standby_req === 1'b1) standby_cnt++;
   task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic rw(input logic [5:0] a, input logic [7:0] d, input logic w, input logic [7:0] e);
      logic [7:0] r;
      host.access(a, d, w, r);
      check($sformatf("reg %h", a), e, r);
   endtask : rw
   task automatic wait_irq(input int lim);
      int n;
      n = irq_seen;
      for (int k = 0; k < lim && irq_seen == n; k++)
         @(negedge clk);
      check("irq edge", 8'h01, {7'h0, irq_seen != n});
   endtask : wait_irq
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   initial begin
      #300000;
      error_cnt++;
      stop_test();
   end
   initial begin
      {tx_payload_phase, tx_eof_phase, rx_stream_end, rx_active, card_presence_sense, card_presence_sense_mode} = '0;
      {frame_start_seen, lpo_on, counter_stop_evt, error_status} = '0;
      command_is_idle = 1'b1;
      fifo_count = 10'd100;
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      check("irq_pin", 8'h00, {7'h0, irq_pin});
      check("stay_powered", 8'h01, {7'h0, stay_powered});
      foreach (rows[i])
         rw(rows[i][21:16], rows[i][15:8], rows[i][22], rows[i][7:0]);
      // one shot, fast clock
      rw(6'h0f, 8'h11, 1'b1, 8'h10);
      wait_irq(200);
      rw(6'h07, 8'h00, 1'b0, 8'h41);
      rw(6'h0f, 8'h00, 1'b0, 8'h00);
      rw(6'h14, 8'h00, 1'b0, 8'h00);
      rw(6'h07, 8'h01, 1'b1, 8'h40);
      rw(6'h07, 8'h40, 1'b1, 8'h00);
      check("irq_pin", 8'h00, {7'h0, irq_pin});
      // periodic
      rw(6'h10, 8'h04, 1'b1, 8'h04);
      rw(6'h0f, 8'h11, 1'b1, 8'h10);
      wait_irq(200);
      host.access(6'h07, 8'h41, 1'b1, q);
      wait_irq(200);
      rw(6'h0f, 8'h01, 1'b1, 8'h00);
      host.access(6'h07, 8'h41, 1'b1, q);
      // slow clock
      rw(6'h10, 8'h01, 1'b1, 8'h01);
      rw(6'h0f, 8'h11, 1'b1, 8'h10);
      repeat (60) @(negedge clk);
      check("slow irq", 8'h00, {7'h0, irq_pin});
      wait_irq(2000);
      host.access(6'h07, 8'h41, 1'b1, q);
      // stop event before underflow
      rw(6'h10, 8'h08, 1'b1, 8'h08);
      rw(6'h0f, 8'h11, 1'b1, 8'h10);
      counter_stop_evt = 4'h1;
      @(negedge clk);
      counter_stop_evt = 4'h0;
      repeat (60) @(negedge clk);
      rw(6'h0f, 8'h00, 1'b0, 8'h00);
      rw(6'h07, 8'h00, 1'b0, 8'h00);
      // start bit in control
      rw(6'h10, 8'h10, 1'b1, 8'h00);
      rw(6'h0f, 8'h00, 1'b0, 8'h10);
      wait_irq(200);
      host.access(6'h07, 8'h41, 1'b1, q);
      // counter 1 clocked by counter 0 underflow
      rw(6'h18, 8'h02, 1'b1, 8'h02);
      rw(6'h0f, 8'h33, 1'b1, 8'h30);
      wait_irq(200);
      rw(6'h07, 8'h00, 1'b0, 8'h43);
      rw(6'h0f, 8'h00, 1'b0, 8'h00);
      host.access(6'h07, 8'h43, 1'b1, q);
      // event sources
      tx_payload_phase = 1'b1;
      command_is_idle = 1'b0;
      @(negedge clk);
      {tx_payload_phase, tx_eof_phase, rx_stream_end, command_is_idle} = 4'b0111;
      fifo_count = 10'd496;
      @(negedge clk);
      {rx_stream_end, rx_active, card_presence_sense_mode, card_presence_sense, frame_start_seen} = 5'b01111;
      error_status = 8'h04;
      fifo_count = 10'd16;
      @(negedge clk);
      rw(6'h06, 8'h00, 1'b0, 8'h7f);
      rw(6'h07, 8'h00, 1'b0, 8'h20);
      {rx_active, card_presence_sense_mode, card_presence_sense, frame_start_seen, tx_eof_phase} = '0;
      error_status = 8'h00;
      rw(6'h08, 8'h82, 1'b1, 8'h02);
      rw(6'h07, 8'h00, 1'b0, 8'h60);
      rw(6'h00, 8'h00, 1'b0, 8'h01);
      check("irq_pin", 8'h01, {7'h0, irq_pin});
      host.access(6'h06, 8'h7f, 1'b1, q);
      host.access(6'h07, 8'h7f, 1'b1, q);
      rw(6'h00, 8'h00, 1'b0, 8'h00);
      check("irq_pin", 8'h00, {7'h0, irq_pin});
      // wake counter
      rw(6'h32, 8'h02, 1'b1, 8'h02);
      rw(6'h30, 8'h34, 1'b1, 8'h24);
      check("stay_powered", 8'h00, {7'h0, stay_powered});
      lpo_on = 1'b1;
      for (int k = 0; k < 2000 && standby_cnt == 0; k++)
         @(negedge clk);
      check("standby", 8'h01, {7'h0, standby_cnt != 0});
      lpo_on = 1'b0;
      rw(6'h07, 8'h00, 1'b0, 8'h10);
      rw(6'h30, 8'h00, 1'b1, 8'h00);
      check("stay_powered", 8'h01, {7'h0, stay_powered});
      stop_test();
   end
endmodule : tiu_unit_tb_top
`default_nettype wire
